// ==== verilog/port_cfg_pkg.sv ====
// constants for the port pin configuration register block
`default_nettype none
package port_cfg_pkg;
    localparam logic [7:0] addr_port1_data = 8'h90;
    localparam logic [7:0] addr_port2_data = 8'ha0;
    localparam logic [7:0] addr_port1_drv = 8'ha5;
    localparam logic [7:0] addr_port0_byp = 8'hd4;
    localparam logic [7:0] addr_port1_byp = 8'hd5;
    localparam logic [7:0] addr_port1_ana = 8'hf2;
    localparam logic [7:0] rst_port1_data = 8'hff;
    localparam logic rst_port2_data = 1'b1;
    localparam logic [7:0] rst_port1_drv = 8'h00;
    localparam logic [7:0] rst_port0_byp = 8'h00;
    localparam logic [6:0] rst_port1_byp = 7'h00;
    localparam logic [7:0] rst_port1_ana = 8'hff;
    localparam int port1_byp_width = 7;
    // bit-addressable window: a byte address with low three bits as bit index
    localparam logic [4:0] bit_base_port1 = 5'h12;
    localparam logic [4:0] bit_base_port2 = 5'h14;
endpackage
`default_nettype wire

// ==== verilog/pin_sync.sv ====
// two-flop synchroniser for a bundle of pin levels
`default_nettype none
module pin_sync #(
    parameter int width = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // pins
    input wire logic [width-1:0] pin_async,
    output logic [width-1:0] pin_sync_out
);
    logic [width-1:0] meta_ff;
    logic [width-1:0] sync_ff;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pin_async;
            sync_ff <= meta_ff;
        end
    end
    assign pin_sync_out = sync_ff;
endmodule
`default_nettype wire

// ==== verilog/pin_cell_ctrl.sv ====
// per-pin driver and receiver control derived from mode bits
`default_nettype none
module pin_cell_ctrl (
    // mode and data
    input wire logic latch_val,
    input wire logic digital_mode,
    input wire logic push_pull,
    // cell controls
    output logic drive_val,
    output logic drive_oe,
    output logic pullup_en,
    output logic receiver_en
);
    // open-drain drives only the low level; high is left to the pull-up
    always_comb begin
        drive_val = latch_val;
        drive_oe = digital_mode & (push_pull | ~latch_val);
        pullup_en = digital_mode;
        receiver_en = digital_mode;
    end
endmodule
`default_nettype wire

// ==== verilog/port_pin_config_registers.sv ====
// port 0/1/2 pin configuration and data registers on the sfr bus
`default_nettype none
module port_pin_config_registers (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // byte access in special function register space
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_rmw,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // bit access in the bit-addressable space
    input wire logic [7:0] bit_addr,
    input wire logic bit_wr,
    input wire logic bit_rd,
    input wire logic bit_rmw,
    input wire logic bit_wdata,
    output logic bit_rdata,
    // pin levels from the pads
    input wire logic [7:0] port1_pin_in,
    input wire logic port2_pin_in,
    // port 1 cell controls
    output logic [7:0] port1_out,
    output logic [7:0] port1_oe,
    output logic [7:0] port1_pullup_en,
    output logic [7:0] port1_receiver_en,
    // port 2 cell
    output logic port2_out,
    // crossbar skip marks
    output logic [7:0] port0_skip,
    output logic [6:0] port1_skip
);
    logic [7:0] p1_latch_ff, nxt_p1_latch;
    logic p2_latch_ff, nxt_p2_latch;
    logic [7:0] p1_drv_ff, nxt_p1_drv;
    logic [7:0] p0_byp_ff, nxt_p0_byp;
    logic [6:0] p1_byp_ff, nxt_p1_byp;
    logic [7:0] p1_ana_ff, nxt_p1_ana;
    logic [7:0] rdata_ff, nxt_rdata;
    logic bit_rdata_ff, nxt_bit_rdata;
    logic [7:0] p1_out_ff, p1_oe_ff, p1_pu_ff, p1_rx_ff;
    logic [7:0] cell_val, cell_oe, cell_pu, cell_rx;
    logic [7:0] p1_pin_s;
    logic p2_pin_s;
    logic [2:0] bit_idx;
    logic bit_p1, bit_p2;

    ////////////////////////////////////////////////////////////////////////
    pin_sync #(.width(8)) u_sync_p1 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_async(port1_pin_in),
        .pin_sync_out(p1_pin_s)
    );
    pin_sync #(.width(1)) u_sync_p2 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_async(port2_pin_in),
        .pin_sync_out(p2_pin_s)
    );

    ////////////////////////////////////////////////////////////////////////
    assign bit_idx = bit_addr[2:0];
    assign bit_p1 = (bit_addr[7:3] == port_cfg_pkg::bit_base_port1);
    assign bit_p2 = (bit_addr[7:3] == port_cfg_pkg::bit_base_port2);

    always_comb begin
        nxt_p1_latch = p1_latch_ff;
        nxt_p2_latch = p2_latch_ff;
        nxt_p1_drv = p1_drv_ff;
        nxt_p0_byp = p0_byp_ff;
        nxt_p1_byp = p1_byp_ff;
        nxt_p1_ana = p1_ana_ff;
        if (sfr_wr) begin
            unique case (sfr_addr)
                port_cfg_pkg::addr_port1_data: nxt_p1_latch = sfr_wdata;
                port_cfg_pkg::addr_port2_data: nxt_p2_latch = sfr_wdata[0];
                port_cfg_pkg::addr_port1_drv: nxt_p1_drv = sfr_wdata;
                port_cfg_pkg::addr_port0_byp: nxt_p0_byp = sfr_wdata;
                // bit 7 has no storage
                port_cfg_pkg::addr_port1_byp:
                    nxt_p1_byp = sfr_wdata[port_cfg_pkg::port1_byp_width-1:0];
                port_cfg_pkg::addr_port1_ana: nxt_p1_ana = sfr_wdata;
                default: ;
            endcase
        end
        if (bit_wr && bit_p1) begin
            nxt_p1_latch[bit_idx] = bit_wdata;
        end
        // only bit 0 of port 2 exists
        if (bit_wr && bit_p2 && (bit_idx == 3'h0)) begin
            nxt_p2_latch = bit_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_rdata = rdata_ff;
        if (sfr_rd) begin
            unique case (sfr_addr)
                // rmw takes the latch so pulled-down open-drain highs survive
                port_cfg_pkg::addr_port1_data:
                    nxt_rdata = sfr_rmw ? p1_latch_ff : p1_pin_s;
                port_cfg_pkg::addr_port2_data:
                    nxt_rdata = {7'h00, sfr_rmw ? p2_latch_ff : p2_pin_s};
                port_cfg_pkg::addr_port1_drv: nxt_rdata = p1_drv_ff;
                port_cfg_pkg::addr_port0_byp: nxt_rdata = p0_byp_ff;
                port_cfg_pkg::addr_port1_byp: nxt_rdata = {1'b0, p1_byp_ff};
                port_cfg_pkg::addr_port1_ana: nxt_rdata = p1_ana_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
        nxt_bit_rdata = bit_rdata_ff;
        if (bit_rd) begin
            if (bit_p1) begin
                nxt_bit_rdata = bit_rmw ? p1_latch_ff[bit_idx] : p1_pin_s[bit_idx];
            end else if (bit_p2 && (bit_idx == 3'h0)) begin
                nxt_bit_rdata = bit_rmw ? p2_latch_ff : p2_pin_s;
            end else begin
                nxt_bit_rdata = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < 8; i++) begin : g_cell
        pin_cell_ctrl u_cell (
            .latch_val(p1_latch_ff[i]),
            .digital_mode(p1_ana_ff[i]),
            .push_pull(p1_drv_ff[i]),
            .drive_val(cell_val[i]),
            .drive_oe(cell_oe[i]),
            .pullup_en(cell_pu[i]),
            .receiver_en(cell_rx[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            p1_latch_ff <= port_cfg_pkg::rst_port1_data;
            p2_latch_ff <= port_cfg_pkg::rst_port2_data;
            p1_drv_ff <= port_cfg_pkg::rst_port1_drv;
            p0_byp_ff <= port_cfg_pkg::rst_port0_byp;
            p1_byp_ff <= port_cfg_pkg::rst_port1_byp;
            p1_ana_ff <= port_cfg_pkg::rst_port1_ana;
            rdata_ff <= 8'h00;
            bit_rdata_ff <= 1'b0;
            p1_out_ff <= port_cfg_pkg::rst_port1_data;
            p1_oe_ff <= 8'h00;
            p1_pu_ff <= port_cfg_pkg::rst_port1_ana;
            p1_rx_ff <= port_cfg_pkg::rst_port1_ana;
        end else begin
            p1_latch_ff <= nxt_p1_latch;
            p2_latch_ff <= nxt_p2_latch;
            p1_drv_ff <= nxt_p1_drv;
            p0_byp_ff <= nxt_p0_byp;
            p1_byp_ff <= nxt_p1_byp;
            p1_ana_ff <= nxt_p1_ana;
            rdata_ff <= nxt_rdata;
            bit_rdata_ff <= nxt_bit_rdata;
            // cell controls follow config with one cycle of lag
            p1_out_ff <= cell_val;
            p1_oe_ff <= cell_oe;
            p1_pu_ff <= cell_pu;
            p1_rx_ff <= cell_rx;
        end
    end

    assign sfr_rdata = rdata_ff;
    assign bit_rdata = bit_rdata_ff;
    assign port1_out = p1_out_ff;
    assign port1_oe = p1_oe_ff;
    assign port1_pullup_en = p1_pu_ff;
    assign port1_receiver_en = p1_rx_ff;
    assign port2_out = p2_latch_ff;
    assign port0_skip = p0_byp_ff;
    assign port1_skip = p1_byp_ff;
endmodule
`default_nettype wire

// ==== verification/port_pin_config_registers_checker.sv ====
// assertions on the port configuration block ports
`default_nettype none
module port_pin_config_registers_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // byte access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // cell controls and skip marks
    input wire logic [7:0] port1_oe,
    input wire logic [7:0] port1_pullup_en,
    input wire logic [7:0] port1_receiver_en,
    input wire logic [7:0] port0_skip,
    input wire logic [6:0] port1_skip
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_skip_load:
        assert property (sfr_wr && sfr_addr == 8'hd4 |=> port0_skip == $past(sfr_wdata))
        else $error("port 0 skip not loaded");
    a_skip1_load:
        assert property (sfr_wr && sfr_addr == 8'hd5 |=> port1_skip == $past(sfr_wdata[6:0]))
        else $error("port 1 skip not loaded");
    a_skip_readback:
        assert property (sfr_rd && sfr_addr == 8'hd4 |=> sfr_rdata == $past(port0_skip))
        else $error("port 0 skip readback wrong");
    a_skip1_top:
        assert property (sfr_rd && sfr_addr == 8'hd5 |=> sfr_rdata[7] == 1'b0)
        else $error("port 1 skip bit 7 not zero");
    a_p2_upper:
        assert property (sfr_rd && sfr_addr == 8'ha0 |=> sfr_rdata[7:1] == 7'h00)
        else $error("port 2 upper bits not zero");
    a_mode_cells:
        assert property (sfr_wr && sfr_addr == 8'hf2 |-> ##2
            port1_pullup_en == $past(sfr_wdata, 2) && port1_receiver_en == port1_pullup_en)
        else $error("mode bits not reflected in cells");
    a_analog_quiet:
        assert property ((port1_oe & ~port1_receiver_en) == 8'h00)
        else $error("analog pin driven");
    a_push_drive:
        assert property (sfr_wr && sfr_addr == 8'ha5 |-> ##2
            (port1_receiver_en & $past(sfr_wdata, 2) & ~port1_oe) == 8'h00)
        else $error("push-pull pin not driven");
endmodule
`default_nettype wire

// ==== verification/core_model.sv ====
// processor core model issuing byte and bit register accesses
`default_nettype none
module core_model (
    // clock
    input wire logic clk_sys,
    // register access
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic sfr_rmw,
    output logic [7:0] sfr_wdata,
    output logic [7:0] bit_addr,
    output logic bit_wr,
    output logic bit_rd,
    output logic bit_rmw,
    output logic bit_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic bit_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {sfr_wr, sfr_rd, sfr_rmw, bit_wr, bit_rd, bit_rmw} = 6'h00;
    initial {sfr_addr, sfr_wdata, bit_addr, bit_wdata} = 25'h0000000;
    // idle lines show inverted values so stale data never looks valid
    task automatic xfer(input logic bs, input logic w, input logic m, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        #1;
        if (bs) {bit_addr, bit_wdata, bit_wr, bit_rd, bit_rmw} = {a, d[0], w, !w, m};
        else {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, sfr_rmw} = {a, d, w, !w, m};
        @(posedge clk_sys);
        #1;
        {sfr_wr, sfr_rd, sfr_rmw, bit_wr, bit_rd, bit_rmw} = 6'h00;
        {sfr_addr, sfr_wdata, bit_addr, bit_wdata} = ~{a, d, a, d[0]};
        q = bs ? {7'h00, bit_rdata} : sfr_rdata;
    endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the port configuration register block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, sys_rst, sfr_wr, sfr_rd, sfr_rmw, bit_wr, bit_rd, bit_rmw, bit_wdata;
    logic bit_rdata, port2_pin_in, port2_out;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, port1_pin_in, port1_out, q;
    logic [7:0] port1_oe, port1_pullup_en, port1_receiver_en, port0_skip;
    logic [6:0] port1_skip;
    logic [7:0] ra [6] = '{8'h90, 8'ha0, 8'ha5, 8'hd4, 8'hd5, 8'hf2};
    logic [7:0] rv [6] = '{8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'hff};
    int n_errors = 0;
    int n_checks = 0;
    port_pin_config_registers u_port_pin_config_registers (.*);
    core_model core (.*);
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        core.xfer(1'b0, 1'b1, 1'b0, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e, input string n);
        core.xfer(1'b0, 1'b0, m, a, 8'h00, q);
        chk(n, q, e);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // whole run is well under a thousand cycles
    initial begin
        #20000;
        n_errors++;
        complete_run();
    end
    initial begin
        sys_rst = 1'b1;
        port1_pin_in = 8'h5a;
        port2_pin_in = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        for (int i = 0; i < 6; i++) rd(ra[i], 1'b1, rv[i], "reset value");
        wr(8'hd4, 8'hff);
        wr(8'hd5, 8'hff);
        rd(8'hd4, 1'b0, 8'hff, "port0 bypass");
        rd(8'hd5, 1'b0, 8'h7f, "port1 bypass");
        chk("port0 skip", port0_skip, 8'hff);
        chk("port1 skip", {1'b0, port1_skip}, 8'h7f);
        wr(8'h90, 8'h3c);
        rd(8'h90, 1'b0, 8'h5a, "port1 pins");
        rd(8'h90, 1'b1, 8'h3c, "port1 latch");
        chk("open drain oe", port1_oe, 8'hc3);
        chk("port1 out", port1_out, 8'h3c);
        core.xfer(1'b1, 1'b0, 1'b1, 8'h92, 8'h00, q);
        chk("port1 bit latch", q, 8'h01);
        core.xfer(1'b1, 1'b0, 1'b0, 8'h92, 8'h00, q);
        chk("port1 bit pin", q, 8'h00);
        wr(8'ha5, 8'hcf);
        wr(8'hf2, 8'h3f);
        @(posedge clk_sys);
        #1;
        chk("oe", port1_oe, 8'h0f);
        chk("pullup", port1_pullup_en, 8'h3f);
        chk("receiver", port1_receiver_en, 8'h3f);
        wr(8'ha0, 8'hfe);
        rd(8'ha0, 1'b1, 8'h00, "port2 latch");
        rd(8'ha0, 1'b0, 8'h01, "port2 pin");
        core.xfer(1'b1, 1'b1, 1'b0, 8'ha0, 8'h01, q);
        core.xfer(1'b1, 1'b0, 1'b0, 8'h93, 8'h00, q);
        chk("port1 bit", q, 8'h01);
        chk("port2 out", {7'h00, port2_out}, 8'h01);
        core.xfer(1'b1, 1'b0, 1'b0, 8'ha0, 8'h00, q);
        chk("port2 bit pin", q, 8'h01);
        core.xfer(1'b1, 1'b0, 1'b0, 8'ha3, 8'h00, q);
        chk("port2 upper bit", q, 8'h00);
        wr(8'hd5, 8'h00);
        rd(8'h90, 1'b0, 8'h5a, "pins under crossbar");
        rd(8'h55, 1'b0, 8'h00, "unmapped");
        complete_run();
    end
endmodule
bind port_pin_config_registers port_pin_config_registers_checker u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .port1_oe(port1_oe),
    .port1_pullup_en(port1_pullup_en), .port1_receiver_en(port1_receiver_en),
    .port0_skip(port0_skip), .port1_skip(port1_skip));
`default_nettype wire
